// ==== design/rail_window_pkg.sv ====
// Package with register map, reset values, timing constants and carrier types
package rail_window_pkg;
    // Register offsets
    localparam logic [7:0] CH2_LOWFREQ_CUTOFF_SELECT_ADDR = 8'h35;
    localparam logic [7:0] CH3_HIGHFREQ_UNDER_THRESHOLD_ADDR = 8'h40;
    localparam logic [7:0] CH3_HIGHFREQ_OVER_THRESHOLD_ADDR = 8'h41;
    localparam logic [7:0] CH3_LOWFREQ_UNDER_THRESHOLD_ADDR = 8'h42;
    localparam logic [7:0] CH3_LOWFREQ_OVER_THRESHOLD_ADDR = 8'h43;
    localparam logic [7:0] CH3_HIGHFREQ_DEBOUNCE_ADDR = 8'h44;
    // Reset values
    localparam logic [7:0] UNDER_THRESHOLD_RESET = 8'h00;
    localparam logic [7:0] OVER_THRESHOLD_RESET = 8'hff;
    localparam logic [7:0] DEBOUNCE_RESET = 8'h00;
    localparam logic [7:0] CUTOFF_SELECT_RESET = 8'h04;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Field positions
    localparam int CUTOFF_CODE_MSB = 2;
    localparam int OVER_DEB_LSB = 4;
    localparam int UNDER_DEB_LSB = 0;
    // Cutoff codes: 250 Hz, 500 Hz, 1 kHz, 2 kHz, 4 kHz
    localparam logic [2:0] CUTOFF_250HZ = 3'h2;
    localparam logic [2:0] CUTOFF_500HZ = 3'h3;
    localparam logic [2:0] CUTOFF_1KHZ = 3'h4;
    localparam logic [2:0] CUTOFF_2KHZ = 3'h5;
    localparam logic [2:0] CUTOFF_4KHZ = 3'h6;
    // Debounce timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEB_BASE_NS = 100;
    localparam logic [11:0] DEB_BASE_CYCLES = 12'((DEB_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] DEB_MAX_SHIFT = 4'ha;
    // Threshold scaling in millivolts
    localparam logic [12:0] MV_BASE_1X = 13'h00c8;
    localparam logic [12:0] MV_STEP_1X = 13'h0005;
    localparam logic [12:0] MV_BASE_4X = 13'h0320;
    localparam logic [12:0] MV_STEP_4X = 13'h0014;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic hf_over;
        logic hf_under;
        logic lf_over;
        logic lf_under;
    } fault_t;
endpackage

// ==== design/rail_window_threshold_filter_regs.sv ====
// Channel threshold, debounce and cutoff registers with comparators and debouncers
// Functional notes
// - Cutoff codes 010..110 select 250 Hz..4 kHz
// - Valid cutoff write (code 010..110) reloads low-frequency filter
// - High-frequency under threshold bounds below
// - High-frequency over threshold bounds above
// - Low-frequency under threshold bounds below
// - Low-frequency over threshold bounds above
// - Scale 1x: 0.2 V plus 5 mV/code
// - Scale 4x: 0.8 V plus 20 mV/code
// - Reset: under 0x00, over 0xff, debounce 0x00
// - High-frequency faults assert after stable debounce time
// - Debounce 0.1 us doubling, 102.4 us cap
`timescale 1ns/1ps
module rail_window_threshold_filter_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register access
    input wire rail_window_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata_reg,
    // Monitored samples and scaling
    input wire logic [7:0] hf_sample,
    input wire logic [7:0] lf_sample,
    input wire logic threshold_scaling_select,
    // Filter control
    output logic [2:0] lowfreq_cutoff_select_reg,
    output logic filter_reload_reg,
    // Faults and scaled thresholds
    output rail_window_pkg::fault_t fault_reg,
    output logic [12:0] hf_under_mv_reg,
    output logic [12:0] hf_over_mv_reg
);
    logic [7:0] cutoff_raw_reg;
    logic [7:0] hf_under_reg;
    logic [7:0] hf_over_reg;
    logic [7:0] lf_under_reg;
    logic [7:0] lf_over_reg;
    logic [7:0] debounce_reg;
    logic [7:0] rdata_next;
    logic [1:0] raw_cmp;
    logic [1:0] deb_fault;
    logic [11:0] deb_limit [2];
    logic [11:0] deb_cnt_reg [2];
    logic cutoff_wr;

    function automatic logic cutoff_valid(input logic [2:0] code);
        cutoff_valid = (code >= rail_window_pkg::CUTOFF_250HZ) && (code <= rail_window_pkg::CUTOFF_4KHZ);
    endfunction

    function automatic logic [11:0] deb_cycles(input logic [3:0] code);
        logic [3:0] sh;
        sh = (code > rail_window_pkg::DEB_MAX_SHIFT) ? rail_window_pkg::DEB_MAX_SHIFT : code;
        deb_cycles = rail_window_pkg::DEB_BASE_CYCLES << sh;
    endfunction

    function automatic logic [12:0] code_to_mv(input logic [7:0] code, input logic scale4x);
        if (scale4x) begin
            code_to_mv = rail_window_pkg::MV_BASE_4X + 13'(code) * rail_window_pkg::MV_STEP_4X;
        end else begin
            code_to_mv = rail_window_pkg::MV_BASE_1X + 13'(code) * rail_window_pkg::MV_STEP_1X;
        end
    endfunction

    assign cutoff_wr = reg_req.wr && (reg_req.addr == rail_window_pkg::CH2_LOWFREQ_CUTOFF_SELECT_ADDR);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cutoff_raw_reg <= rail_window_pkg::CUTOFF_SELECT_RESET;
            hf_under_reg <= rail_window_pkg::UNDER_THRESHOLD_RESET;
            hf_over_reg <= rail_window_pkg::OVER_THRESHOLD_RESET;
            lf_under_reg <= rail_window_pkg::UNDER_THRESHOLD_RESET;
            lf_over_reg <= rail_window_pkg::OVER_THRESHOLD_RESET;
            debounce_reg <= rail_window_pkg::DEBOUNCE_RESET;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                rail_window_pkg::CH2_LOWFREQ_CUTOFF_SELECT_ADDR: cutoff_raw_reg <= reg_req.wdata;
                rail_window_pkg::CH3_HIGHFREQ_UNDER_THRESHOLD_ADDR: hf_under_reg <= reg_req.wdata;
                rail_window_pkg::CH3_HIGHFREQ_OVER_THRESHOLD_ADDR: hf_over_reg <= reg_req.wdata;
                rail_window_pkg::CH3_LOWFREQ_UNDER_THRESHOLD_ADDR: lf_under_reg <= reg_req.wdata;
                rail_window_pkg::CH3_LOWFREQ_OVER_THRESHOLD_ADDR: lf_over_reg <= reg_req.wdata;
                rail_window_pkg::CH3_HIGHFREQ_DEBOUNCE_ADDR: debounce_reg <= reg_req.wdata;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (reg_req.addr)
            rail_window_pkg::CH2_LOWFREQ_CUTOFF_SELECT_ADDR: rdata_next = cutoff_raw_reg;
            rail_window_pkg::CH3_HIGHFREQ_UNDER_THRESHOLD_ADDR: rdata_next = hf_under_reg;
            rail_window_pkg::CH3_HIGHFREQ_OVER_THRESHOLD_ADDR: rdata_next = hf_over_reg;
            rail_window_pkg::CH3_LOWFREQ_UNDER_THRESHOLD_ADDR: rdata_next = lf_under_reg;
            rail_window_pkg::CH3_LOWFREQ_OVER_THRESHOLD_ADDR: rdata_next = lf_over_reg;
            rail_window_pkg::CH3_HIGHFREQ_DEBOUNCE_ADDR: rdata_next = debounce_reg;
            default: rdata_next = rail_window_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata_reg <= rail_window_pkg::UNMAPPED_READ;
        end else if (reg_req.rd) begin
            reg_rdata_reg <= rdata_next;
        end
    end

    // effective cutoff keeps last valid code
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lowfreq_cutoff_select_reg <= rail_window_pkg::CUTOFF_1KHZ;
        end else if (cutoff_wr && cutoff_valid(reg_req.wdata[rail_window_pkg::CUTOFF_CODE_MSB:0])) begin
            lowfreq_cutoff_select_reg <= reg_req.wdata[rail_window_pkg::CUTOFF_CODE_MSB:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            filter_reload_reg <= 1'b0;
        end else begin
            filter_reload_reg <= cutoff_wr && cutoff_valid(reg_req.wdata[rail_window_pkg::CUTOFF_CODE_MSB:0]);
        end
    end

    assign raw_cmp[0] = hf_sample > hf_over_reg;
    assign raw_cmp[1] = hf_sample < hf_under_reg;
    assign deb_limit[0] = deb_cycles(debounce_reg[rail_window_pkg::OVER_DEB_LSB +: 4]);
    assign deb_limit[1] = deb_cycles(debounce_reg[rail_window_pkg::UNDER_DEB_LSB +: 4]);

    generate
        for (genvar i = 0; i < 2; i++) begin : g_deb
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    deb_cnt_reg[i] <= 12'h000;
                end else if (!raw_cmp[i]) begin
                    deb_cnt_reg[i] <= 12'h000;
                end else if (deb_cnt_reg[i] < deb_limit[i]) begin
                    deb_cnt_reg[i] <= deb_cnt_reg[i] + 12'h001;
                end
            end
            assign deb_fault[i] = raw_cmp[i] && (deb_cnt_reg[i] >= deb_limit[i] - 12'h001);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fault_reg <= '0;
        end else begin
            fault_reg.hf_over <= deb_fault[0];
            fault_reg.hf_under <= deb_fault[1];
            fault_reg.lf_over <= lf_sample > lf_over_reg;
            fault_reg.lf_under <= lf_sample < lf_under_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hf_under_mv_reg <= rail_window_pkg::MV_BASE_1X;
            hf_over_mv_reg <= rail_window_pkg::MV_BASE_1X;
        end else begin
            hf_under_mv_reg <= code_to_mv(hf_under_reg, threshold_scaling_select);
            hf_over_mv_reg <= code_to_mv(hf_over_reg, threshold_scaling_select);
        end
    end

    // reference run length of the over comparator
    logic [11:0] over_run_reg;
    always_ff @(posedge clk) begin
        if (!reset_n || !(hf_sample > hf_over_reg)) begin
            over_run_reg <= 12'h000;
        end else if (over_run_reg != 12'hfff) begin
            over_run_reg <= over_run_reg + 12'h001;
        end
    end

    a_cutoff_valid: assert property (@(posedge clk) disable iff (!reset_n)
        lowfreq_cutoff_select_reg >= 3'h2 && lowfreq_cutoff_select_reg <= 3'h6)
        else $error("cutoff code out of range");
    a_cutoff_reload: assert property (@(posedge clk) disable iff (!reset_n)
        cutoff_wr && reg_req.wdata[2:0] >= 3'h2 && reg_req.wdata[2:0] <= 3'h6
        |=> filter_reload_reg && lowfreq_cutoff_select_reg == $past(reg_req.wdata[2:0]))
        else $error("valid cutoff write not applied");
    a_cutoff_invalid: assert property (@(posedge clk) disable iff (!reset_n)
        cutoff_wr && (reg_req.wdata[2:0] < 3'h2 || reg_req.wdata[2:0] == 3'h7)
        |=> !filter_reload_reg && $stable(lowfreq_cutoff_select_reg))
        else $error("invalid cutoff code took effect");
    a_reset_values: assert property (@(posedge clk)
        !reset_n |=> hf_under_reg == 8'h00 && hf_over_reg == 8'hff && lf_under_reg == 8'h00
        && lf_over_reg == 8'hff && debounce_reg == 8'h00 && cutoff_raw_reg == 8'h04)
        else $error("wrong reset value");
    a_readback_value: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_req.wr && reg_req.addr == 8'h44) ##1 !reg_req.wr
        ##1 (reg_req.rd && !reg_req.wr && reg_req.addr == 8'h44)
        |=> reg_rdata_reg == $past(reg_req.wdata, 3))
        else $error("readback mismatch");
    a_lf_over_cmp: assert property (@(posedge clk) disable iff (!reset_n)
        lf_sample > lf_over_reg |=> fault_reg.lf_over)
        else $error("low-frequency over fault missed");
    a_lf_under_cmp: assert property (@(posedge clk) disable iff (!reset_n)
        lf_sample < lf_under_reg |=> fault_reg.lf_under)
        else $error("low-frequency under fault missed");
    a_hf_over_stable: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(fault_reg.hf_over) |-> $past(raw_cmp[0], 1) && $past(raw_cmp[0], 2))
        else $error("over fault without stable comparator");
    a_hf_under_stable: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(fault_reg.hf_under) |-> $past(raw_cmp[1], 1) && $past(raw_cmp[1], 2) && !$past(deb_cnt_reg[1] == 12'h000))
        else $error("under fault without stable comparator");
    a_deb_time_code: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(fault_reg.hf_over) |-> $past(over_run_reg) + 12'h001
        == (12'h002 << (($past(debounce_reg[7:4]) > 4'ha) ? 4'ha : $past(debounce_reg[7:4]))))
        else $error("debounce time wrong");
    a_mv_scaling: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> hf_over_mv_reg == ($past(threshold_scaling_select) ? 13'h320 + 13'($past(hf_over_reg)) * 13'h014
        : 13'h0c8 + 13'($past(hf_over_reg)) * 13'h005))
        else $error("threshold scaling wrong");

    c_cutoff_change: cover property (@(posedge clk) disable iff (!reset_n) filter_reload_reg);
    c_hf_over_fault: cover property (@(posedge clk) disable iff (!reset_n) $rose(fault_reg.hf_over));
    c_hf_under_fault: cover property (@(posedge clk) disable iff (!reset_n) $rose(fault_reg.hf_under));
    c_lf_fault: cover property (@(posedge clk) disable iff (!reset_n) fault_reg.lf_over || fault_reg.lf_under);
endmodule

// ==== verif/rail_window_threshold_filter_regs_tb_top.sv ====
// Testbench for the channel threshold, debounce and cutoff registers
`timescale 1ns/1ps
module rail_window_threshold_filter_regs_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    rail_window_pkg::reg_req_t reg_req = '0;
    logic [7:0] hf_sample = 8'h50;
    logic [7:0] lf_sample = 8'h50;
    logic threshold_scaling_select = 1'b0;
    logic [7:0] reg_rdata_reg;
    logic [2:0] lowfreq_cutoff_select_reg;
    logic filter_reload_reg;
    rail_window_pkg::fault_t fault_reg;
    logic [12:0] hf_under_mv_reg;
    logic [12:0] hf_over_mv_reg;
    logic [7:0] tv [4] = '{8'h20, 8'h80, 8'h40, 8'hc0};
    logic [7:0] ls [4] = '{8'h3f, 8'hc1, 8'hc0, 8'h40};
    logic [3:0] lf_exp [4] = '{4'h1, 4'h2, 4'h0, 4'h0};
    logic [2:0] cut;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int n;

    always #25 clk = ~clk;

    rail_window_threshold_filter_regs i_dut (
        .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata_reg(reg_rdata_reg),
        .hf_sample(hf_sample), .lf_sample(lf_sample), .threshold_scaling_select(threshold_scaling_select),
        .lowfreq_cutoff_select_reg(lowfreq_cutoff_select_reg), .filter_reload_reg(filter_reload_reg),
        .fault_reg(fault_reg), .hf_under_mv_reg(hf_under_mv_reg), .hf_over_mv_reg(hf_over_mv_reg)
    );

    task automatic end_of_test();
        $display("Counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req <= {1'b1, 1'b0, a, d};
        @(negedge clk);
        reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        reg_req <= '0;
        chk(13'(reg_rdata_reg), 13'(exp));
    endtask

    initial begin
        repeat (3) @(negedge clk);
        reset_n <= 1'b1;
        rd(8'h35, 8'h04);
        rd(8'h40, 8'h00);
        rd(8'h41, 8'hff);
        rd(8'h42, 8'h00);
        rd(8'h43, 8'hff);
        rd(8'h44, 8'h00);
        chk(hf_under_mv_reg, 13'h00c8);
        chk(hf_over_mv_reg, 13'h05c3);
        $display("Test reset values done");
        wr(8'h46, 8'h5a);
        rd(8'h46, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h40 + 8'(k), tv[k]);
        end
        for (int k = 0; k < 4; k++) begin
            rd(8'h40 + 8'(k), tv[k]);
        end
        chk(hf_under_mv_reg, 13'h0168);
        chk(hf_over_mv_reg, 13'h0348);
        threshold_scaling_select <= 1'b1;
        repeat (2) @(negedge clk);
        chk(hf_under_mv_reg, 13'h05a0);
        chk(hf_over_mv_reg, 13'h0d20);
        wr(8'h41, 8'hff);
        @(negedge clk);
        chk(hf_over_mv_reg, 13'h170c);
        wr(8'h41, 8'h80);
        threshold_scaling_select <= 1'b0;
        $display("Test readback and scaling done");
        for (int k = 0; k < 4; k++) begin
            lf_sample <= ls[k];
            @(negedge clk);
            chk(13'(fault_reg), 13'(lf_exp[k]));
        end
        $display("Test low-frequency faults done");
        for (int k = 0; k < 16; k++) begin
            wr(8'h44, {4'(k), 4'h0});
            rd(8'h44, {4'(k), 4'h0});
            n = 2 << ((k > 10) ? 10 : k);
            hf_sample <= 8'h81;
            repeat (n - 1) @(negedge clk);
            chk(13'(fault_reg), 13'h0);
            @(negedge clk);
            chk(13'(fault_reg), 13'h8);
            hf_sample <= 8'h50;
            @(negedge clk);
            chk(13'(fault_reg), 13'h0);
        end
        wr(8'h44, 8'h02);
        hf_sample <= 8'h1f;
        repeat (7) @(negedge clk);
        hf_sample <= 8'h20;
        @(negedge clk);
        hf_sample <= 8'h1f;
        repeat (7) @(negedge clk);
        chk(13'(fault_reg), 13'h0);
        @(negedge clk);
        chk(13'(fault_reg), 13'h4);
        hf_sample <= 8'h50;
        $display("Test debounce done");
        cut = 3'h4;
        for (int k = 0; k < 8; k++) begin
            wr(8'h35, {5'h15, 3'(k)});
            chk(13'(filter_reload_reg), 13'(k >= 2 && k <= 6));
            if (k >= 2 && k <= 6) begin
                cut = 3'(k);
            end
            chk(13'(lowfreq_cutoff_select_reg), 13'(cut));
            @(negedge clk);
            chk(13'(filter_reload_reg), 13'h0);
            rd(8'h35, {5'h15, 3'(k)});
        end
        $display("Test cutoff codes done");
        end_of_test();
    end
endmodule
